// ---- design/mdi_ctrl.sv ----
// DMA start demand, receive length check and interrupt enable slice of the Ethernet MAC
//
// What this block does
// - Transmit mover halts when no descriptor owned
// - Any transmit demand write restarts halted transmit mover
// - Transmit demand register is write only
// - Receive mover halts when no descriptor available
// - Receive demand write restarts only halted mover
// - Receive demand register is write only
// - Max length low 16 bits, resets 2048
// - Oversize frame sets flag and receive interrupt only while enable bit 8 is set
// - Separate receive and transmit interrupt lines
// - Interrupt enable resets to all zeros
// - Bus fault interrupt needs bit 24, master
// - Transmit no descriptor interrupt needs bit 23, master
// - Late collision interrupt needs bit 22, master
// - Enable zero masks, one passes status
// - Cleared transmit master blocks all transmit interrupts
`timescale 1ns/1ns
`include "mdi_params.svh"

module mdi_ctrl
(
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire mdi_pkg::mdi_word_t s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire mdi_pkg::mdi_word_t s_axi_wdata_i,
    input  wire mdi_pkg::mdi_strb_t s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output mdi_pkg::mdi_resp_t     s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire mdi_pkg::mdi_word_t s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output mdi_pkg::mdi_word_t     s_axi_rdata_o,
    output mdi_pkg::mdi_resp_t     s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    output logic                   tx_desc_req_o,
    input  wire logic              tx_desc_ack_i,
    input  wire logic              tx_desc_owned_i,
    output logic                   tx_frame_go_o,
    input  wire logic              tx_frame_done_i,
    input  wire logic              tx_bus_fault_i,
    input  wire logic              late_collision_i,
    output logic                   rx_desc_req_o,
    input  wire logic              rx_desc_ack_i,
    input  wire logic              rx_desc_owned_i,
    output logic                   rx_store_en_o,
    input  wire logic              rx_frame_done_i,
    input  wire mdi_pkg::mdi_len_t rx_frame_len_i,
    output logic                   transmit_irq_o,
    output logic                   receive_irq_o,
    output logic                   irq_o
);
    import mdi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave state

    mdi_word_t     aw_addr;
    logic          aw_full;
    mdi_word_t     w_data;
    mdi_strb_t     w_strb;
    logic          w_full;
    mdi_word_t     byte_mask;
    logic          do_write;
    logic          wr_hit;
    logic          rd_hit;
    mdi_word_t     rd_word;

    mdi_len_t      max_frame_bytes;
    mdi_word_t     interrupt_enable;
    mdi_word_t     interrupt_status;
    mdi_word_t     mac_command;
    mdi_word_t     status_set;
    mdi_word_t     status_clr;
    logic          tx_demand_value;
    logic          rx_demand_value;

    mdi_tx_state_e tx_state;
    mdi_tx_state_e next_tx_state;
    mdi_rx_state_e rx_state;
    mdi_rx_state_e next_rx_state;
    logic          transmit_on;
    logic          receive_on;
    logic          tx_halt_entry;
    logic          rx_halt_entry;
    logic          oversize_flag;

    assign transmit_on = mac_command[`MDI_BIT_TRANSMIT_ON];
    assign receive_on  = mac_command[`MDI_BIT_RECEIVE_ON];

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data are taken in either order

    assign s_axi_awready_o = !aw_full && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_full && !s_axi_bvalid_o;
    assign do_write        = aw_full && w_full && !s_axi_bvalid_o;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            aw_full <= 1'b0;
            aw_addr <= `MDI_ZERO_WORD;
        end
        else if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
        end
        else if (do_write)
        begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            w_full <= 1'b0;
            w_data <= `MDI_ZERO_WORD;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
        end
        else if (do_write)
        begin
            w_full <= 1'b0;
        end
    end

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1)
        begin : g_byte_mask
            assign byte_mask[gb*8 +: 8] = {8{w_strb[gb]}};
        end
    endgenerate

    always_comb
    begin
        unique case (aw_addr)
            `MDI_ADDR_TX_DEMAND,
            `MDI_ADDR_RX_DEMAND,
            `MDI_ADDR_MAX_LEN,
            `MDI_ADDR_INT_EN,
            `MDI_ADDR_INT_STAT,
            `MDI_ADDR_MAC_CMD,
            `MDI_ADDR_DMA_STATE: wr_hit = 1'b1;
            default:             wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `MDI_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? `MDI_RESP_OKAY : `MDI_RESP_DECERR;
        end
        else if (s_axi_bready_i)
        begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Any data value and any strobe pattern counts as a demand
    assign tx_demand_value = do_write && (aw_addr == `MDI_ADDR_TX_DEMAND);
    assign rx_demand_value = do_write && (aw_addr == `MDI_ADDR_RX_DEMAND);

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            max_frame_bytes <= `MDI_MAXLEN_RST;
        else if (do_write && aw_addr == `MDI_ADDR_MAX_LEN)
            max_frame_bytes <= (max_frame_bytes & ~byte_mask[15:0]) | (w_data[15:0] & byte_mask[15:0]);
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            interrupt_enable <= `MDI_INT_EN_RST;
        else if (do_write && aw_addr == `MDI_ADDR_INT_EN)
            interrupt_enable <= ((interrupt_enable & ~byte_mask) | (w_data & byte_mask)) & `MDI_INT_EN_WMASK;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            mac_command <= `MDI_ZERO_WORD;
        else if (do_write && aw_addr == `MDI_ADDR_MAC_CMD)
            mac_command <= ((mac_command & ~byte_mask) | (w_data & byte_mask)) & `MDI_CMD_WMASK;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky status, write one to clear; a new event wins over the clear

    assign oversize_flag = rx_state == MDI_RX_STORE && rx_frame_done_i
                           && (rx_frame_len_i > max_frame_bytes)
                           && interrupt_enable[`MDI_BIT_OVERSIZE];

    always_comb
    begin
        status_set = `MDI_ZERO_WORD;
        status_set[`MDI_BIT_TX_BUS_FAULT] = tx_bus_fault_i;
        status_set[`MDI_BIT_TX_NO_DESC]   = tx_halt_entry;
        status_set[`MDI_BIT_LATE_COLL]    = late_collision_i;
        status_set[`MDI_BIT_RX_NO_DESC]   = rx_halt_entry;
        status_set[`MDI_BIT_OVERSIZE]     = oversize_flag;
    end

    assign status_clr = (do_write && aw_addr == `MDI_ADDR_INT_STAT) ? (w_data & byte_mask) : `MDI_ZERO_WORD;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            interrupt_status <= `MDI_ZERO_WORD;
        else
            interrupt_status <= ((interrupt_status & ~status_clr) | status_set) & `MDI_STAT_IMPL;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt lines
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            transmit_irq_o <= 1'b0;
            receive_irq_o  <= 1'b0;
            irq_o          <= 1'b0;
        end
        else
        begin
            // A zero enable bit removes its status from the OR
            transmit_irq_o <= interrupt_enable[`MDI_BIT_TX_MASTER]
                              && |(interrupt_status[`MDI_TX_SRC_HI:`MDI_TX_SRC_LO]
                                   & interrupt_enable[`MDI_TX_SRC_HI:`MDI_TX_SRC_LO]);
            receive_irq_o  <= interrupt_enable[`MDI_BIT_RX_MASTER]
                              && |(interrupt_status[`MDI_RX_SRC_HI:`MDI_RX_SRC_LO]
                                   & interrupt_enable[`MDI_RX_SRC_HI:`MDI_RX_SRC_LO]);
            irq_o          <= transmit_irq_o || receive_irq_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit mover
    always_comb
    begin
        next_tx_state = tx_state;
        tx_halt_entry = 1'b0;
        unique case (tx_state)
            MDI_TX_IDLE:
                if (transmit_on)
                    next_tx_state = MDI_TX_FETCH;
            MDI_TX_FETCH:
                if (!transmit_on)
                    next_tx_state = MDI_TX_IDLE;
                else if (tx_desc_ack_i && tx_desc_owned_i)
                    next_tx_state = MDI_TX_SEND;
                else if (tx_desc_ack_i)
                begin
                    next_tx_state = MDI_TX_HALT;
                    tx_halt_entry = 1'b1;
                end
            // A frame under way always completes
            MDI_TX_SEND:
                if (tx_frame_done_i)
                    next_tx_state = transmit_on ? MDI_TX_FETCH : MDI_TX_IDLE;
            MDI_TX_HALT:
                if (!transmit_on)
                    next_tx_state = MDI_TX_IDLE;
                else if (tx_demand_value)
                    next_tx_state = MDI_TX_FETCH;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            tx_state <= MDI_TX_IDLE;
        else
            tx_state <= next_tx_state;
    end
    assign tx_desc_req_o = tx_state == MDI_TX_FETCH && transmit_on;
    assign tx_frame_go_o = tx_state == MDI_TX_SEND;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive mover
    always_comb
    begin
        next_rx_state = rx_state;
        rx_halt_entry = 1'b0;
        unique case (rx_state)
            MDI_RX_IDLE:
                if (receive_on)
                    next_rx_state = MDI_RX_FETCH;
            MDI_RX_FETCH:
                if (!receive_on)
                    next_rx_state = MDI_RX_IDLE;
                else if (rx_desc_ack_i && rx_desc_owned_i)
                    next_rx_state = MDI_RX_STORE;
                else if (rx_desc_ack_i)
                begin
                    next_rx_state = MDI_RX_HALT;
                    rx_halt_entry = 1'b1;
                end
            MDI_RX_STORE:
                if (rx_frame_done_i)
                    next_rx_state = receive_on ? MDI_RX_FETCH : MDI_RX_IDLE;
            MDI_RX_HALT:
                if (!receive_on)
                    next_rx_state = MDI_RX_IDLE;
                else if (rx_demand_value)
                    next_rx_state = MDI_RX_FETCH;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rx_state <= MDI_RX_IDLE;
        else
            rx_state <= next_rx_state;
    end
    assign rx_desc_req_o = rx_state == MDI_RX_FETCH && receive_on;
    assign rx_store_en_o = rx_state == MDI_RX_STORE;

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel

    always_comb
    begin
        rd_hit  = 1'b1;
        rd_word = `MDI_ZERO_WORD;
        unique case (s_axi_araddr_i)
            // Demand registers hold nothing; they answer zero
            `MDI_ADDR_TX_DEMAND: rd_word = `MDI_ZERO_WORD;
            `MDI_ADDR_RX_DEMAND: rd_word = `MDI_ZERO_WORD;
            `MDI_ADDR_MAX_LEN:   rd_word = {16'h0000, max_frame_bytes};
            `MDI_ADDR_INT_EN:    rd_word = interrupt_enable;
            `MDI_ADDR_INT_STAT:  rd_word = interrupt_status;
            `MDI_ADDR_MAC_CMD:   rd_word = mac_command;
            `MDI_ADDR_DMA_STATE:
            begin
                rd_word[`MDI_BIT_TX_HALTED] = tx_state == MDI_TX_HALT;
                rd_word[`MDI_BIT_RX_HALTED] = rx_state == MDI_RX_HALT;
            end
            default:             rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready_o = !s_axi_rvalid_o;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= `MDI_ZERO_WORD;
            s_axi_rresp_o  <= `MDI_RESP_OKAY;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_word;
            s_axi_rresp_o  <= rd_hit ? `MDI_RESP_OKAY : `MDI_RESP_DECERR;
        end
        else if (s_axi_rready_i)
        begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
endmodule // mdi_ctrl

// ---- design/mdi_params.svh ----
// Register map, field positions, reset values and bus codes of the DMA demand and interrupt enable block
`ifndef MDI_PARAMS_SVH
`define MDI_PARAMS_SVH
`define MDI_ADDR_TX_DEMAND  32'hB00030A0
`define MDI_ADDR_RX_DEMAND  32'hB00030A4
`define MDI_ADDR_MAX_LEN    32'hB00030A8
`define MDI_ADDR_INT_EN     32'hB00030AC
`define MDI_ADDR_INT_STAT   32'hB00030B0
`define MDI_ADDR_MAC_CMD    32'hB00030B4
`define MDI_ADDR_DMA_STATE  32'hB00030B8
`define MDI_MAXLEN_RST      16'h0800
`define MDI_INT_EN_RST      32'h00000000
`define MDI_INT_EN_WMASK    32'h01FF4FFF
`define MDI_STAT_IMPL       32'h01C00500
`define MDI_CMD_WMASK       32'h00000101
`define MDI_ZERO_WORD       32'h00000000
`define MDI_BIT_TX_BUS_FAULT   24
`define MDI_BIT_TX_NO_DESC     23
`define MDI_BIT_LATE_COLL      22
`define MDI_BIT_TX_MASTER      16
`define MDI_BIT_RX_NO_DESC     10
`define MDI_BIT_OVERSIZE       8
`define MDI_BIT_RX_MASTER      0
`define MDI_TX_SRC_HI          24
`define MDI_TX_SRC_LO          17
`define MDI_RX_SRC_HI          15
`define MDI_RX_SRC_LO          1
`define MDI_BIT_RECEIVE_ON     0
`define MDI_BIT_TRANSMIT_ON    8
`define MDI_BIT_TX_HALTED      0
`define MDI_BIT_RX_HALTED      1
`define MDI_RESP_OKAY          2'h0
`define MDI_RESP_DECERR        2'h3
`endif

// ---- design/mdi_pkg.sv ----
// Types shared by the DMA demand and interrupt enable block
package mdi_pkg;
    typedef logic [31:0] mdi_word_t;
    typedef logic [15:0] mdi_len_t;
    typedef logic [3:0]  mdi_strb_t;
    typedef logic [1:0]  mdi_resp_t;
    typedef enum logic [1:0] {MDI_TX_IDLE, MDI_TX_FETCH, MDI_TX_SEND, MDI_TX_HALT} mdi_tx_state_e;
    typedef enum logic [1:0] {MDI_RX_IDLE, MDI_RX_FETCH, MDI_RX_STORE, MDI_RX_HALT} mdi_rx_state_e;
endpackage

// ---- test/mdi_ctrl_sva.sv ----
// Port-level checks of the DMA demand and interrupt enable block
`timescale 1ns/1ns

module mdi_ctrl_sva
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic tx_desc_req_o,
    input wire logic tx_desc_ack_i,
    input wire logic tx_desc_owned_i,
    input wire logic tx_frame_go_o,
    input wire logic tx_frame_done_i,
    input wire logic rx_desc_req_o,
    input wire logic rx_desc_ack_i,
    input wire logic rx_desc_owned_i,
    input wire logic rx_store_en_o,
    input wire logic transmit_irq_o,
    input wire logic receive_irq_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_tx_ack(o);
        tx_desc_req_o && tx_desc_ack_i && tx_desc_owned_i == o;
    endsequence
    sequence s_rx_ack(o);
        rx_desc_req_o && rx_desc_ack_i && rx_desc_owned_i == o;
    endsequence
    sequence s_wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence

    property p_tx_halt;
        s_tx_ack(1'b0) |=> !tx_desc_req_o && !tx_frame_go_o;
    endproperty
    property p_tx_send;
        s_tx_ack(1'b1) |=> tx_frame_go_o && !tx_desc_req_o;
    endproperty
    property p_rx_halt;
        s_rx_ack(1'b0) |=> !rx_desc_req_o && !rx_store_en_o;
    endproperty
    property p_rx_store;
        s_rx_ack(1'b1) |=> rx_store_en_o;
    endproperty
    property p_go_stands;
        tx_frame_go_o && !tx_frame_done_i |=> tx_frame_go_o;
    endproperty
    // Combined line trails the two lines by exactly one register stage
    property p_irq_or;
        1'b1 |=> irq_o == $past(transmit_irq_o || receive_irq_o);
    endproperty
    property p_b_answer;
        s_wr_taken |-> ##[1:2] s_axi_bvalid_o;
    endproperty
    property p_b_stands;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o;
    endproperty
    property p_r_answer;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
    endproperty

    a_tx_halt: assert property (p_tx_halt) else $error("tx mover kept going without descriptor");
    a_tx_send: assert property (p_tx_send) else $error("tx mover did not send on owned descriptor");
    a_rx_halt: assert property (p_rx_halt) else $error("rx mover kept going without descriptor");
    a_rx_store: assert property (p_rx_store) else $error("rx mover did not store");
    a_go_stands: assert property (p_go_stands) else $error("tx frame dropped before done");
    a_irq_or: assert property (p_irq_or) else $error("combined irq wrong");
    a_b_answer: assert property (p_b_answer) else $error("write response late");
    a_b_stands: assert property (p_b_stands) else $error("bvalid dropped early");
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
endmodule // mdi_ctrl_sva

bind mdi_ctrl mdi_ctrl_sva i_mdi_ctrl_sva (.*);

// ---- test/mdi_mover_model.sv ----
// Behavioural descriptor and frame partner for one mover direction
`timescale 1ns/1ns

module mdi_mover_model
(
    input  wire logic       clk_i,
    input  wire logic       req_i,
    input  wire logic       busy_i,
    input  wire logic       own_i,
    input  wire logic [3:0] lat_i,
    output logic            ack_o = 1'b0,
    output logic            owned_o = 1'b0,
    output logic            done_o = 1'b0
);
    logic [3:0] wait_q = 4'h0;
    logic       junk_q = 1'b0;

    // Owned line toggles outside the answer cycle so a stale value never passes
    always @(posedge clk_i)
    begin
        junk_q <= ~junk_q;
        ack_o <= 1'b0;
        done_o <= 1'b0;
        owned_o <= junk_q;
        if ((req_i || busy_i) && !ack_o && !done_o && wait_q != lat_i)
            wait_q <= wait_q + 4'h1;
        else if ((req_i || busy_i) && !ack_o && !done_o)
        begin
            wait_q <= 4'h0;
            ack_o <= req_i;
            done_o <= busy_i;
            owned_o <= own_i;
        end
        else
            wait_q <= 4'h0;
    end
endmodule // mdi_mover_model

// ---- test/test_mdi_ctrl.sv ----
// Self-checking bench of the DMA demand and interrupt enable block
`timescale 1ns/1ns
`include "mdi_params.svh"

module test_mdi_ctrl;
    import mdi_pkg::*;

    logic       clk_i, rst_b_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, tx_own;
    logic       s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, rx_own;
    logic       s_axi_rready_i, tx_desc_req_o, tx_desc_ack_i, tx_desc_owned_i, tx_frame_go_o;
    logic       tx_frame_done_i, tx_bus_fault_i, late_collision_i, rx_desc_req_o, rx_desc_ack_i;
    logic       rx_desc_owned_i, rx_store_en_o, rx_frame_done_i, transmit_irq_o, receive_irq_o, irq_o;
    logic [3:0] tx_lat, rx_lat;
    mdi_word_t  s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o, rd, en;
    mdi_strb_t  s_axi_wstrb_i;
    mdi_resp_t  s_axi_bresp_o, s_axi_rresp_o, rs;
    mdi_len_t   rx_frame_len_i, max_len;
    int         mismatches, samples_checked, s, b;

    mdi_ctrl i_mdi_ctrl (.*);
    mdi_mover_model i_mdi_mover_model_tx (.clk_i(clk_i), .req_i(tx_desc_req_o), .busy_i(tx_frame_go_o),
        .own_i(tx_own), .lat_i(tx_lat), .ack_o(tx_desc_ack_i), .owned_o(tx_desc_owned_i), .done_o(tx_frame_done_i));
    mdi_mover_model i_mdi_mover_model_rx (.clk_i(clk_i), .req_i(rx_desc_req_o), .busy_i(rx_store_en_o),
        .own_i(rx_own), .lat_i(rx_lat), .ack_o(rx_desc_ack_i), .owned_o(rx_desc_owned_i), .done_o(rx_frame_done_i));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic exp_tx(input mdi_word_t e, input int k);
        return e[`MDI_BIT_TX_MASTER] & e[k];
    endfunction

    task automatic chk(input string nm, input mdi_word_t e, input mdi_word_t g);
        samples_checked++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask

    // Handshakes are judged just before the edge so the decision matches what the edge samples
    task automatic axi_wr(input mdi_word_t a, input mdi_word_t d);
        logic aw, w, bk;
        bk = 1'b0;
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        while (!bk)
        begin
            @(negedge clk_i);
            aw = s_axi_awvalid_i && s_axi_awready_o;
            w = s_axi_wvalid_i && s_axi_wready_o;
            bk = s_axi_bvalid_o;
            rs = s_axi_bresp_o;
            @(posedge clk_i);
            if (aw)
                s_axi_awvalid_i <= 1'b0;
            if (w)
                s_axi_wvalid_i <= 1'b0;
            if (bk)
                s_axi_bready_i <= 1'b0;
        end
    endtask

    task automatic axi_rd(input mdi_word_t a);
        logic ar, rv;
        rv = 1'b0;
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        while (!rv)
        begin
            @(negedge clk_i);
            ar = s_axi_arvalid_i && s_axi_arready_o;
            rv = s_axi_rvalid_o;
            rd = s_axi_rdata_o;
            rs = s_axi_rresp_o;
            @(posedge clk_i);
            if (ar)
                s_axi_arvalid_i <= 1'b0;
            if (rv)
                s_axi_rready_i <= 1'b0;
        end
    endtask

    task automatic rd_chk(input mdi_word_t a, input mdi_word_t m, input mdi_word_t e, input string nm);
        axi_rd(a);
        chk(nm, e, rd & m);
    endtask

    task automatic poll(input mdi_word_t a, input mdi_word_t m);
        int n;
        n = 0;
        rd = 32'h0;
        while ((rd & m) == 32'h0 && n < 40)
        begin
            axi_rd(a);
            n++;
        end
        chk("poll", m, rd & m);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end

    initial
    begin
        rst_b_i = 1'b0;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h00;
        {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i} = 96'h0;
        s_axi_wstrb_i = 4'hF;
        {tx_bus_fault_i, late_collision_i, tx_own, rx_own} = 4'h0;
        rx_frame_len_i = 16'h0000;
        mismatches = 0;
        samples_checked = 0;
        void'($urandom(41));
        tx_lat = 4'($urandom % 4);
        rx_lat = 4'($urandom % 6);
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd_chk(`MDI_ADDR_MAX_LEN, 32'hFFFFFFFF, 32'h00000800, "max_len reset");
        rd_chk(`MDI_ADDR_INT_EN, 32'hFFFFFFFF, `MDI_INT_EN_RST, "int_en reset");
        @(negedge clk_i);
        chk("irq reset", 32'h0, {29'h0, transmit_irq_o, receive_irq_o, irq_o});
        rd_chk(`MDI_ADDR_RX_DEMAND, 32'hFFFFFFFF, 32'h0, "rx demand read");
        chk("demand resp", {30'h0, `MDI_RESP_OKAY}, {30'h0, rs});
        axi_wr(32'hB00030BC, $urandom);
        chk("unmapped wr", {30'h0, `MDI_RESP_DECERR}, {30'h0, rs});
        axi_wr(`MDI_ADDR_MAX_LEN, 32'hFFFFFFFF);
        rd_chk(`MDI_ADDR_MAX_LEN, 32'hFFFFFFFF, 32'h0000FFFF, "max_len reserved");
        axi_wr(`MDI_ADDR_INT_EN, 32'hFFFFFFFF);
        rd_chk(`MDI_ADDR_INT_EN, 32'hFFFFFFFF, 32'h01FF4FFF, "int_en reserved");
        $display("test registers done");

        axi_wr(`MDI_ADDR_INT_EN, 32'h0);
        axi_wr(`MDI_ADDR_MAC_CMD, 32'h00000100);
        poll(`MDI_ADDR_DMA_STATE, 32'h1);
        chk("tx halted", 32'h1, rd & 32'h1);
        rd_chk(`MDI_ADDR_INT_STAT, 32'hFFFFFFFF, 32'h00800000, "tx no desc");
        tx_own <= 1'b1;
        axi_wr(`MDI_ADDR_TX_DEMAND, $urandom);
        rd_chk(`MDI_ADDR_DMA_STATE, 32'h1, 32'h0, "tx resumed");
        tx_own <= 1'b0;
        poll(`MDI_ADDR_DMA_STATE, 32'h1);
        $display("test tx demand done");

        // Every transmit source meets all four enable and master combinations, other transmit source enables and the receive master zero, the rest random
        for (s = 0; s < 12; s++)
        begin
            b = 24 - s % 3;
            en = $urandom & `MDI_INT_EN_WMASK & 32'hFE3EFFFE;
            en[b] = 1'((s / 3) % 2);
            en[`MDI_BIT_TX_MASTER] = 1'(s / 6);
            axi_wr(`MDI_ADDR_INT_STAT, 32'hFFFFFFFF);
            axi_wr(`MDI_ADDR_INT_EN, en);
            tx_bus_fault_i <= (b == 24);
            late_collision_i <= (b == 22);
            @(posedge clk_i);
            tx_bus_fault_i <= 1'b0;
            late_collision_i <= 1'b0;
            if (b == 23)
                axi_wr(`MDI_ADDR_TX_DEMAND, $urandom);
            poll(`MDI_ADDR_INT_STAT, 32'h1 << b);
            repeat (3) @(negedge clk_i);
            chk("tx irq", {31'h0, exp_tx(en, b)}, {31'h0, transmit_irq_o});
            chk("irq", {31'h0, exp_tx(en, b)}, {31'h0, irq_o});
            axi_wr(`MDI_ADDR_INT_STAT, 32'h1 << b);
            repeat (3) @(negedge clk_i);
            chk("tx irq cleared", 32'h0, {31'h0, transmit_irq_o});
        end
        $display("test tx irq done");

        axi_wr(`MDI_ADDR_MAC_CMD, 32'h00000001);
        poll(`MDI_ADDR_DMA_STATE, 32'h2);
        chk("rx halted", 32'h2, rd & 32'h2);
        max_len = 16'(1519 + $urandom % 2000);
        axi_wr(`MDI_ADDR_MAX_LEN, {16'h0, max_len});
        axi_wr(`MDI_ADDR_INT_EN, 32'h00000101);
        rx_frame_len_i <= max_len;
        rx_own <= 1'b1;
        axi_wr(`MDI_ADDR_RX_DEMAND, $urandom);
        rd_chk(`MDI_ADDR_DMA_STATE, 32'h2, 32'h0, "rx resumed");
        axi_wr(`MDI_ADDR_INT_STAT, 32'hFFFFFFFF);
        repeat (30) @(posedge clk_i);
        rd_chk(`MDI_ADDR_INT_STAT, 32'h100, 32'h0, "len at max");
        rx_frame_len_i <= max_len + 16'h1;
        poll(`MDI_ADDR_INT_STAT, 32'h100);
        repeat (3) @(negedge clk_i);
        chk("rx irq on", 32'h1, {31'h0, receive_irq_o});
        axi_wr(`MDI_ADDR_INT_EN, 32'h00000100);
        repeat (3) @(negedge clk_i);
        chk("rx master off", 32'h0, {31'h0, receive_irq_o});
        axi_wr(`MDI_ADDR_INT_EN, 32'h00000001);
        axi_wr(`MDI_ADDR_INT_STAT, 32'hFFFFFFFF);
        repeat (30) @(posedge clk_i);
        rd_chk(`MDI_ADDR_INT_STAT, 32'h100, 32'h0, "oversize masked");
        $display("test rx length done");
        print_verdict();
    end
endmodule // test_mdi_ctrl
